// file: pkg/pef_consts.svh
// Constants for the protection enable and charge switch action block.
// Assumes inclusion by bare name from package and design files.
`ifndef PEF_CONSTS_SVH
`define PEF_CONSTS_SVH

`define PEF_CLK_MHZ        100
`define PEF_DLY_NORM_MS    250
`define PEF_DLY_SLEEP_MS   1000
`define PEF_DLY_NORM_CYC   (`PEF_DLY_NORM_MS * 1000 * `PEF_CLK_MHZ)
`define PEF_DLY_SLEEP_CYC  (`PEF_DLY_SLEEP_MS * 1000 * `PEF_CLK_MHZ)

`define PEF_ADDR_W         8
`define PEF_DATA_W         32
`define PEF_REG_W          8

`define PEF_OFS_EN_A       8'h00
`define PEF_OFS_EN_B       8'h04
`define PEF_OFS_EN_C       8'h08
`define PEF_OFS_ACT_A      8'h0c
`define PEF_OFS_ACT_B      8'h10
`define PEF_OFS_ST_A       8'h14
`define PEF_OFS_ST_B       8'h18
`define PEF_OFS_ST_C       8'h1c
`define PEF_OFS_MSK_A      8'h20
`define PEF_OFS_MSK_B      8'h24
`define PEF_OFS_MSK_C      8'h28
`define PEF_OFS_CTRL       8'h2c

`define PEF_RST_EN_A       8'h88
`define PEF_RST_EN_B       8'h00
`define PEF_RST_EN_C       8'h00
`define PEF_RST_ACT_A      8'h98
`define PEF_RST_ACT_B      8'hd5
`define PEF_RST_MSK        8'h00

`define PEF_VLD_EN_A       8'hfc
`define PEF_VLD_EN_B       8'hf7
`define PEF_VLD_EN_C       8'hf6
`define PEF_VLD_ACT_A      8'h98
`define PEF_VLD_ACT_B      8'hd5

`define PEF_ACT_A_FAST0    8'h98
`define PEF_ACT_A_FAST1    8'h18

`define PEF_CTRL_SLEEP     0
`define PEF_CTRL_CHG_OFF   1
`define PEF_CTRL_PENDING   2

`endif

// file: pkg/pef_pkg.sv
// Types and decode helpers for the protection enable block.
// Assumes pef_consts.svh is on the include path.
`include "pef_consts.svh"

package pef_pkg;

  typedef struct packed {
    logic                     en;
    logic [`PEF_ADDR_W-1:0]   addr;
    logic [`PEF_REG_W-1:0]    data;
  } pef_wr_t;

  typedef struct packed {
    logic [`PEF_REG_W-1:0] a;
    logic [`PEF_REG_W-1:0] b;
    logic [`PEF_REG_W-1:0] c;
  } pef_grp_t;

  // Known register offsets
  function automatic logic pef_addr_ok(input logic [`PEF_ADDR_W-1:0] addr);
    case (addr)
      `PEF_OFS_EN_A, `PEF_OFS_EN_B, `PEF_OFS_EN_C,
      `PEF_OFS_ACT_A, `PEF_OFS_ACT_B,
      `PEF_OFS_ST_A, `PEF_OFS_ST_B, `PEF_OFS_ST_C,
      `PEF_OFS_MSK_A, `PEF_OFS_MSK_B, `PEF_OFS_MSK_C,
      `PEF_OFS_CTRL: pef_addr_ok = 1'b1;
      default:       pef_addr_ok = 1'b0;
    endcase
  endfunction : pef_addr_ok

endpackage : pef_pkg

// file: core/pef_apb_slave.sv
// APB slave front end: no wait states, registered read data.
// Assumes the owner supplies read data for the address held in setup.
`timescale 1ns/1ps
`default_nettype none
`include "pef_consts.svh"

module pef_apb_slave (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`PEF_ADDR_W-1:0] i_paddr,
  input  wire logic [`PEF_DATA_W-1:0] i_pwdata,
  input  wire logic [`PEF_REG_W-1:0]  i_rdata,
  output logic      [`PEF_DATA_W-1:0] o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  output pef_pkg::pef_wr_t            o_wr
);

  logic setup;
  logic access;
  logic addr_ok;

  assign setup   = i_psel & ~i_penable;
  assign access  = i_psel & i_penable;
  assign addr_ok = pef_pkg::pef_addr_ok(i_paddr);

  assign o_pready  = access;
  assign o_pslverr = access & ~addr_ok;

  // Write takes effect at the completing edge only
  assign o_wr = '{en:   access & i_pwrite & addr_ok,
                  addr: i_paddr,
                  data: i_pwdata[`PEF_REG_W-1:0]};

  // Read data captured in setup, upper bits zero, unmapped reads zero
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= '0;
    end else if (setup) begin
      o_prdata <= (addr_ok && !i_pwrite)
                  ? {{(`PEF_DATA_W-`PEF_REG_W){1'b0}}, i_rdata} : '0;
    end
  end

endmodule : pef_apb_slave
`default_nettype wire

// file: core/pef_top.sv
// Protection enable and charge switch action settings with fault flags.
// Assumes fault inputs come from same-clock detector logic, APB host.
//
// Function
// - A fault sets its safety flag only when its enable bit is one.
// - Enable A: short, tier2, tier1, charge overcurrent, overvoltage, undervoltage; 0x88.
// - Enable B: temperature protections, bit 3 reserved; default 0x00.
// - Enable C: tier3, latches, precharge timeout, watchdog; bits 3,0 reserved.
// - Enables govern flags only; action masks alone decide switch turn-off.
// - Action bit one turns charge switch off on that fault; zero leaves it.
// - Action A: short circuit, charge overcurrent, overvoltage; default 0x98.
// - Action B: five temperature bits, independently selectable; default 0xd5.
// - Other action A values may delay turn-off: 250 ms normal, 1 s sleep.
`timescale 1ns/1ps
`default_nettype none
`include "pef_consts.svh"

module pef_top #(
  parameter int unsigned DLY_NORM_CYC  = `PEF_DLY_NORM_CYC,
  parameter int unsigned DLY_SLEEP_CYC = `PEF_DLY_SLEEP_CYC
) (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`PEF_ADDR_W-1:0] i_paddr,
  input  wire logic [`PEF_DATA_W-1:0] i_pwdata,
  output logic      [`PEF_DATA_W-1:0] o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  input  wire pef_pkg::pef_grp_t      i_fault,
  output pef_pkg::pef_grp_t           o_safety_flag,
  output logic                        o_charge_switch_off,
  output logic                        o_irq
);

  pef_pkg::pef_wr_t  wr;
  logic [`PEF_REG_W-1:0] rdata;

  logic [`PEF_REG_W-1:0] en_r [3];
  logic [`PEF_REG_W-1:0] st_r [3];
  logic [`PEF_REG_W-1:0] msk_r [3];
  logic [`PEF_REG_W-1:0] act_a_r;
  logic [`PEF_REG_W-1:0] act_b_r;
  logic                  sleep_r;
  logic [`PEF_REG_W-1:0] flt [3];
  logic [`PEF_REG_W-1:0] vld_en [3];
  logic [`PEF_ADDR_W-1:0] ofs_en [3];
  logic [`PEF_ADDR_W-1:0] ofs_st [3];
  logic [`PEF_ADDR_W-1:0] ofs_msk [3];

  assign flt[0]     = i_fault.a;
  assign flt[1]     = i_fault.b;
  assign flt[2]     = i_fault.c;
  assign vld_en[0]  = `PEF_VLD_EN_A;
  assign vld_en[1]  = `PEF_VLD_EN_B;
  assign vld_en[2]  = `PEF_VLD_EN_C;
  assign ofs_en[0]  = `PEF_OFS_EN_A;
  assign ofs_en[1]  = `PEF_OFS_EN_B;
  assign ofs_en[2]  = `PEF_OFS_EN_C;
  assign ofs_st[0]  = `PEF_OFS_ST_A;
  assign ofs_st[1]  = `PEF_OFS_ST_B;
  assign ofs_st[2]  = `PEF_OFS_ST_C;
  assign ofs_msk[0] = `PEF_OFS_MSK_A;
  assign ofs_msk[1] = `PEF_OFS_MSK_B;
  assign ofs_msk[2] = `PEF_OFS_MSK_C;

  pef_apb_slave pef_apb_slave_i (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_paddr   (i_paddr),
    .i_pwdata  (i_pwdata),
    .i_rdata   (rdata),
    .o_prdata  (o_prdata),
    .o_pready  (o_pready),
    .o_pslverr (o_pslverr),
    .o_wr      (wr)
  );

  // Write strobe for one register offset
  function automatic logic wr_hit(input pef_pkg::pef_wr_t w,
                                  input logic [`PEF_ADDR_W-1:0] ofs);
    wr_hit = w.en && (w.addr == ofs);
  endfunction : wr_hit

  // Enable, status and interrupt mask per group
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_grp
      logic [`PEF_REG_W-1:0] set;
      logic [`PEF_REG_W-1:0] clr;

      // Only enabled protections raise their flag
      assign set = flt[g] & en_r[g];
      assign clr = wr_hit(wr, ofs_st[g]) ? wr.data : '0;

      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          en_r[g] <= (g == 0) ? `PEF_RST_EN_A
                   : (g == 1) ? `PEF_RST_EN_B : `PEF_RST_EN_C;
        end else if (wr_hit(wr, ofs_en[g])) begin
          en_r[g] <= wr.data & vld_en[g];
        end
      end

      // Sticky flags, set wins over write-one clear
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          st_r[g] <= '0;
        end else begin
          st_r[g] <= ((st_r[g] & ~clr) | set) & vld_en[g];
        end
      end

      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          msk_r[g] <= `PEF_RST_MSK;
        end else if (wr_hit(wr, ofs_msk[g])) begin
          msk_r[g] <= wr.data & vld_en[g];
        end
      end
    end
  endgenerate

  assign o_safety_flag = '{a: st_r[0], b: st_r[1], c: st_r[2]};

  // Level interrupt while any unmasked flag stands
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |((st_r[0] & msk_r[0]) | (st_r[1] & msk_r[1])
                 | (st_r[2] & msk_r[2]));
    end
  end

  // Charge switch action masks
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      act_a_r <= `PEF_RST_ACT_A;
    end else if (wr_hit(wr, `PEF_OFS_ACT_A)) begin
      act_a_r <= wr.data & `PEF_VLD_ACT_A;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      act_b_r <= `PEF_RST_ACT_B;
    end else if (wr_hit(wr, `PEF_OFS_ACT_B)) begin
      act_b_r <= wr.data & `PEF_VLD_ACT_B;
    end
  end

  // Normal or sleep mode select
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sleep_r <= 1'b0;
    end else if (wr_hit(wr, `PEF_OFS_CTRL)) begin
      sleep_r <= wr.data[`PEF_CTRL_SLEEP];
    end
  end

  // Turn-off requests, independent of the enable bits
  logic trip_a;
  logic trip_b;
  logic fast_a;
  logic pend_r;
  logic [31:0] dly_cnt_r;
  logic [31:0] dly_lim;
  logic dly_done;

  assign trip_a = |(i_fault.a & act_a_r);
  assign trip_b = |(i_fault.b & act_b_r);
  assign fast_a = (act_a_r == `PEF_ACT_A_FAST0)
                | (act_a_r == `PEF_ACT_A_FAST1);
  assign dly_lim = sleep_r ? DLY_SLEEP_CYC : DLY_NORM_CYC;
  assign dly_done = pend_r && (dly_cnt_r >= dly_lim - 32'd1);

  // Slow path: group A turn-off waits out the postponement
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pend_r <= 1'b0;
    end else if (!trip_a || fast_a || dly_done) begin
      pend_r <= 1'b0;
    end else if (!o_charge_switch_off) begin
      pend_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dly_cnt_r <= '0;
    end else if (!pend_r) begin
      dly_cnt_r <= '0;
    end else begin
      dly_cnt_r <= dly_cnt_r + 32'd1;
    end
  end

  // Switch held off while a selected fault stands
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_charge_switch_off <= 1'b0;
    end else begin
      o_charge_switch_off <= trip_b
                           | (trip_a & (fast_a | dly_done
                                        | o_charge_switch_off));
    end
  end

  // Read mux, reserved bits already zero in storage
  always_comb begin
    case (i_paddr)
      `PEF_OFS_EN_A:  rdata = en_r[0];
      `PEF_OFS_EN_B:  rdata = en_r[1];
      `PEF_OFS_EN_C:  rdata = en_r[2];
      `PEF_OFS_ACT_A: rdata = act_a_r;
      `PEF_OFS_ACT_B: rdata = act_b_r;
      `PEF_OFS_ST_A:  rdata = st_r[0];
      `PEF_OFS_ST_B:  rdata = st_r[1];
      `PEF_OFS_ST_C:  rdata = st_r[2];
      `PEF_OFS_MSK_A: rdata = msk_r[0];
      `PEF_OFS_MSK_B: rdata = msk_r[1];
      `PEF_OFS_MSK_C: rdata = msk_r[2];
      `PEF_OFS_CTRL: begin
        rdata = '0;
        rdata[`PEF_CTRL_SLEEP]   = sleep_r;
        rdata[`PEF_CTRL_CHG_OFF] = o_charge_switch_off;
        rdata[`PEF_CTRL_PENDING] = pend_r;
      end
      default:        rdata = '0;
    endcase
  end

endmodule : pef_top
`default_nettype wire

// file: dv/pef_top_properties.sv
// Port-level checks for the protection settings block.
// Assumes bind into pef_top; one clock, async high reset.
`timescale 1ns/1ps
`default_nettype none
`include "pef_consts.svh"

module pef_top_properties #(
  parameter int unsigned DLY_NORM_CYC  = 8,
  parameter int unsigned DLY_SLEEP_CYC = 16
) (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst,
  input wire logic                   i_psel,
  input wire logic                   i_penable,
  input wire logic                   i_pwrite,
  input wire logic [`PEF_ADDR_W-1:0] i_paddr,
  input wire logic [`PEF_DATA_W-1:0] i_pwdata,
  input wire logic [`PEF_DATA_W-1:0] o_prdata,
  input wire logic                   o_pready,
  input wire logic                   o_pslverr,
  input wire pef_pkg::pef_grp_t      i_fault,
  input wire pef_pkg::pef_grp_t      o_safety_flag,
  input wire logic                   o_charge_switch_off,
  input wire logic                   o_irq
);
  localparam logic [23:0] VLD = {`PEF_VLD_EN_A, `PEF_VLD_EN_B, `PEF_VLD_EN_C};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_pready_access: assert property (o_pready == (i_psel && i_penable))
    else $error("pready not tied to access phase");
  a_err_read_zero: assert property (
      o_pslverr |-> i_psel && i_penable && o_prdata == 32'h0)
    else $error("slave error outside access or with data");
  a_flag_cause: assert property (
      (o_safety_flag & ~$past(o_safety_flag) & ~$past(i_fault)) == 24'h0)
    else $error("flag set without fault");
  a_flag_reserved: assert property (
      (o_safety_flag & ~VLD) == 24'h0)
    else $error("reserved flag bit set");
  a_flag_clear_write: assert property (
      (~o_safety_flag & $past(o_safety_flag)) != 24'h0
      |-> $past(i_psel && i_penable && i_pwrite))
    else $error("flag dropped without write");
  a_irq_from_flag: assert property (
      o_safety_flag == 24'h0 |=> !o_irq)
    else $error("irq without flag");
  a_off_cause: assert property (
      $rose(o_charge_switch_off)
      |-> $past((i_fault.a & 8'h98) != 8'h0 || (i_fault.b & 8'hd5) != 8'h0))
    else $error("switch off without selected fault");
  a_off_release: assert property (
      (i_fault.a & 8'h98) == 8'h0 && (i_fault.b & 8'hd5) == 8'h0
      |=> !o_charge_switch_off)
    else $error("switch off held without fault");
  a_prdata_upper: assert property (
      o_prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule : pef_top_properties

bind pef_top pef_top_properties #(.DLY_NORM_CYC(DLY_NORM_CYC), .DLY_SLEEP_CYC(DLY_SLEEP_CYC))
  pef_top_properties_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_fault(i_fault),
  .o_safety_flag(o_safety_flag), .o_charge_switch_off(o_charge_switch_off), .o_irq(o_irq));

`default_nettype wire

// file: dv/pef_top_tb.sv
// Self-checking bench for the protection settings block.
// Assumes short delay parameters; the bench is the APB host.
`timescale 1ns/1ps
`default_nettype none
`include "pef_consts.svh"

module pef_top_tb;
  localparam int DN = 8;
  localparam int DS = 16;
  logic              clk, rst, psel, pen, pwr, pready, perr, serr, off, irq;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rdat;
  pef_pkg::pef_grp_t fault, flag;
  int                err_count, tests_run, n;

  pef_top #(.DLY_NORM_CYC(DN), .DLY_SLEEP_CYC(DS)) pef_top_i (
    .i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(perr), .i_fault(fault), .o_safety_flag(flag),
    .o_charge_switch_off(off), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic give_verdict;
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  // Setup, access until ready, release, one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk);
    if (k == 20) begin
      err_count++;
      give_verdict();
    end
    rdat = prdata;
    serr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic t_regs;
    logic [7:0] ofs [5] = '{`PEF_OFS_EN_A, `PEF_OFS_EN_B, `PEF_OFS_EN_C,
                            `PEF_OFS_ACT_A, `PEF_OFS_ACT_B};
    logic [7:0] dft [5] = '{8'h88, 8'h00, 8'h00, 8'h98, 8'hd5};
    logic [7:0] vld [5] = '{8'hfc, 8'hf7, 8'hf6, 8'h98, 8'hd5};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rdat, {24'h0, dft[i]});
      apb(1'b1, ofs[i], 32'hffff_ffff);
      apb(1'b0, ofs[i], 32'h0);
      chk(rdat, {24'h0, vld[i]});
    end
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, serr}, 32'h1);
    chk(rdat, 32'h0);
  endtask : t_regs

  task automatic t_enable;
    fault <= '1;
    tick(3);
    chk(flag, 32'hfcf7f6);
    fault <= '0;
    tick(2);
    apb(1'b1, `PEF_OFS_ST_A, 32'hff);
    apb(1'b1, `PEF_OFS_ST_B, 32'hff);
    apb(1'b1, `PEF_OFS_ST_C, 32'hff);
    chk(flag, 32'h0);
    apb(1'b1, `PEF_OFS_EN_A, 32'h0);
    apb(1'b1, `PEF_OFS_EN_B, 32'h0);
    apb(1'b1, `PEF_OFS_EN_C, 32'h0);
    fault <= '1;
    tick(3);
    chk(flag, 32'h0);
    chk(off, 32'h1);
    fault <= '0;
    tick(2);
    chk(off, 32'h0);
  endtask : t_enable

  task automatic t_action;
    logic [7:0] v [2] = '{8'h98, 8'h18};
    apb(1'b1, `PEF_OFS_ACT_B, 32'h0);
    fault.b <= 8'hff;
    fault.c <= 8'hff;
    tick(3);
    chk(off, 32'h0);
    fault.c <= 8'h0;
    for (int i = 0; i < 8; i++) begin
      if (8'hd5 & (8'h1 << i)) begin
        apb(1'b1, `PEF_OFS_ACT_B, 32'h1 << i);
        fault.b <= ~(8'h1 << i);
        tick(3);
        chk(off, 32'h0);
        fault.b <= 8'h1 << i;
        tick(3);
        chk(off, 32'h1);
      end
    end
    fault.b <= 8'h0;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `PEF_OFS_ACT_A, {24'h0, v[i]});
      fault.a <= 8'h80;
      tick(2);
      chk(off, {31'h0, v[i][7]});
      fault.a <= 8'h08;
      tick(2);
      chk(off, 32'h1);
      fault.a <= 8'h0;
      tick(2);
    end
  endtask : t_action

  task automatic t_delay;
    apb(1'b1, `PEF_OFS_ACT_A, 32'h08);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, `PEF_OFS_CTRL, s);
      fault.a <= 8'h08;
      for (n = 0; n < 100 && off !== 1'b1; n++) @(posedge clk);
      chk(n <= (s ? DS : DN) + 3, 32'h1);
      chk(n > (s ? DS : DN), 32'h1);
      apb(1'b0, `PEF_OFS_CTRL, 32'h0);
      chk(rdat, 32'h2 | s);
      fault.a <= 8'h0;
      tick(2);
      chk(off, 32'h0);
    end
  endtask : t_delay

  task automatic t_irq;
    apb(1'b1, `PEF_OFS_EN_A, 32'h80);
    apb(1'b1, `PEF_OFS_MSK_A, 32'h80);
    fault.a <= 8'h80;
    tick(1);
    fault.a <= 8'h0;
    tick(3);
    chk(irq, 32'h1);
    apb(1'b1, `PEF_OFS_MSK_A, 32'h0);
    tick(2);
    chk(irq, 32'h0);
    apb(1'b1, `PEF_OFS_MSK_A, 32'h80);
    tick(2);
    chk(irq, 32'h1);
    apb(1'b1, `PEF_OFS_ST_A, 32'h80);
    tick(2);
    chk({irq, flag.a}, 32'h0);
  endtask : t_irq

  // Mid-run reset clears flags and outputs, restores the enable A default
  task automatic t_reset;
    fault <= '1;
    tick(2);
    chk(flag.a, 32'h80);
    rst <= 1'b1;
    tick(2);
    chk({flag, off, irq}, 32'h0);
    rst <= 1'b0;
    fault <= '0;
    @(posedge clk);
    apb(1'b0, `PEF_OFS_EN_A, 32'h0);
    chk(rdat, 32'h88);
  endtask : t_reset

  initial begin
    {psel, pen, pwr, paddr, pwdata} = '0;
    fault = '0;
    err_count = 0;
    tests_run = 0;
    rst = 1'b1;
    tick(10);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_enable();
    t_action();
    t_delay();
    t_irq();
    t_reset();
    give_verdict();
  end
endmodule : pef_top_tb

`default_nettype wire
